// File: core/dma_pkg.sv
// Shared types and constants for the four-channel peripheral/SRAM transfer engine
package dma_pkg;
    // ========================================================================
    // Sizes
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CNT_W = 14;
    localparam int SEL_W = 8;
    localparam int SRC_W = 4;

    // ========================================================================
    // Request source codes
    localparam logic [SRC_W-1:0] SRC_CAN = 4'h0;
    localparam logic [SRC_W-1:0] SRC_ADC = 4'h1;
    localparam logic [SRC_W-1:0] SRC_SPI = 4'h2;
    localparam logic [SRC_W-1:0] SRC_UART = 4'h3;
    localparam logic [SRC_W-1:0] SRC_IC = 4'h4;
    localparam logic [SRC_W-1:0] SRC_OC = 4'h5;
    localparam logic [SRC_W-1:0] SRC_TIMER = 4'h6;
    localparam logic [SRC_W-1:0] SRC_EXTINT = 4'h7;
    localparam logic [SRC_W-1:0] SRC_MANUAL = 4'h8;

    // ========================================================================
    // Reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [NUM_CH-1:0] CH_NONE = 4'h0;

    // Direction: 0 = peripheral to SRAM, 1 = SRAM to peripheral
    localparam logic DIR_TO_SRAM = 1'b0;
    localparam logic DIR_TO_PERIPH = 1'b1;

    // Per-channel configuration
    typedef struct packed {
        logic enable;
        logic dir;
        logic post_inc;
        logic [SRC_W-1:0] source;
        logic [ADDR_W-1:0] periph_addr;
        logic [ADDR_W-1:0] sram_start;
        logic [CNT_W-1:0] count;
    } ch_cfg_t;

    // Memory-side bus request
    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_DONE  = 4'b1000
    } xfer_state_t;
endpackage : dma_pkg

// File: core/dma_ch_state.sv
// Per-channel transfer state: live address, words left, pending request
`timescale 1ns/1ps
`default_nettype none
module dma_ch_state
    import dma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire ch_cfg_t i_cfg,
    input wire logic i_start,
    input wire logic i_trigger,
    input wire logic i_word_done,
    output logic o_pending,
    output logic o_last,
    output logic [ADDR_W-1:0] o_addr
);
    logic [ADDR_W-1:0] addr_reg;
    logic [CNT_W-1:0] left_reg;
    logic pend_reg;
    logic active_reg;
    wire logic [ADDR_W-1:0] addr_step = i_cfg.post_inc ? addr_reg + 16'h0002 : addr_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            addr_reg <= ADDR_RESET;
            left_reg <= CNT_RESET;
            pend_reg <= 1'b0;
            active_reg <= 1'b0;
        end else if (i_start) begin
            addr_reg <= i_cfg.sram_start;
            left_reg <= i_cfg.count;
            active_reg <= 1'b1;
            pend_reg <= 1'b0;
        end else begin
            // A new trigger wins over the service of an older one
            if (i_trigger && active_reg && i_cfg.enable)
                pend_reg <= 1'b1;
            else if (i_word_done)
                pend_reg <= 1'b0;
            if (i_word_done) begin
                addr_reg <= addr_step;
                left_reg <= left_reg - 14'h0001;
                if (left_reg == CNT_RESET)
                    active_reg <= 1'b0;
            end
        end
    end

    assign o_pending = pend_reg;
    assign o_last = (left_reg == CNT_RESET);
    assign o_addr = addr_reg;
endmodule : dma_ch_state
`default_nettype wire

// File: core/peripheral_sram_dma_core.sv
// Four-channel engine copying words between peripheral registers and SRAM
// Summary of operation
// - Copy words between peripheral data registers and SRAM without the CPU.
// - Addresses span the full 16-bit data space.
// - Memory bus goes through shared arbiter; engine stalls until granted.
// - Four channels, each with its own configuration and transfer state.
// - Each channel moves data toward or away from one chosen peripheral.
// - Sources include CAN, ADC, SPI, UART, input capture, output compare.
// - A channel moves data one way only; two channels serve both ways.
// - Fixed priority by channel number; losers stay pending.
// - Block finished raises a per-channel interrupt pulse to the CPU.
// - Timer and external interrupt events may also start transfers.
`timescale 1ns/1ps
`default_nettype none
module peripheral_sram_dma_core
    import dma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire ch_cfg_t [NUM_CH-1:0] i_cfg,
    input wire logic [NUM_CH-1:0] i_start,
    input wire logic [SEL_W-1:0] i_periph_req,
    input wire logic i_grant,
    input wire logic [DATA_W-1:0] i_rdata,
    output bus_req_t o_bus,
    output logic [NUM_CH-1:0] o_block_irq,
    output logic [NUM_CH-1:0] o_busy
);
    // ========================================================================
    // Request routing
    // Sources 0..7 are peripheral, timer and external interrupt lines
    logic [NUM_CH-1:0] trig;
    logic [NUM_CH-1:0] pending;
    logic [NUM_CH-1:0] last;
    logic [NUM_CH-1:0] done_pulse;
    logic [ADDR_W-1:0] ch_addr [NUM_CH];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign trig[g] = (i_cfg[g].source == SRC_MANUAL) ? 1'b0
                           : i_periph_req[i_cfg[g].source[2:0]];
            dma_ch_state u_state (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_cfg(i_cfg[g]),
                .i_start(i_start[g]),
                .i_trigger(trig[g]),
                .i_word_done(done_pulse[g]),
                .o_pending(pending[g]),
                .o_last(last[g]),
                .o_addr(ch_addr[g])
            );
        end
    endgenerate

    // ========================================================================
    // Arbitration
    // lowest number wins
    wire logic [NUM_CH-1:0] winner = pending & (~pending + 4'h1);
    logic [1:0] win_idx;
    always_comb begin
        win_idx = 2'd0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (winner[i])
                win_idx = 2'(i);
        end
    end

    // ========================================================================
    // Transfer sequencer
    xfer_state_t state_reg, state_next;
    logic [1:0] ch_reg;
    logic [DATA_W-1:0] data_reg;
    bus_req_t bus_reg, bus_next;
    logic [NUM_CH-1:0] irq_reg;
    logic [NUM_CH-1:0] busy_reg;
    logic [NUM_CH-1:0] start_seen_reg;

    wire ch_cfg_t cur = i_cfg[ch_reg];
    wire logic to_sram = (cur.dir == DIR_TO_SRAM);
    wire logic [ADDR_W-1:0] rd_addr = to_sram ? cur.periph_addr : ch_addr[ch_reg];
    wire logic [ADDR_W-1:0] wr_addr = to_sram ? ch_addr[ch_reg] : cur.periph_addr;

    always_comb begin
        state_next = state_reg;
        bus_next = bus_reg;
        case (state_reg)
            ST_IDLE: begin
                bus_next.req = 1'b0;
                if (pending != CH_NONE) begin
                    state_next = ST_READ;
                end
            end
            ST_READ: begin
                bus_next.req = 1'b1;
                bus_next.we = 1'b0;
                bus_next.addr = rd_addr;
                if (bus_reg.req && !bus_reg.we && i_grant) begin
                    bus_next.req = 1'b0;
                    state_next = ST_WRITE;
                end
            end
            ST_WRITE: begin
                bus_next.req = 1'b1;
                bus_next.we = 1'b1;
                bus_next.addr = wr_addr;
                bus_next.wdata = data_reg;
                if (bus_reg.req && bus_reg.we && i_grant) begin
                    bus_next.req = 1'b0;
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                bus_next.req = 1'b0;
                state_next = ST_IDLE;
            end
            default: begin
                bus_next = '0;
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            bus_reg <= '0;
            ch_reg <= 2'd0;
            data_reg <= DATA_RESET;
        end else begin
            state_reg <= state_next;
            bus_reg <= bus_next;
            if (state_reg == ST_IDLE)
                ch_reg <= win_idx;
            if (state_reg == ST_READ && bus_reg.req && i_grant)
                data_reg <= i_rdata;
        end
    end

    // ========================================================================
    // Completion and interrupts
    always_comb begin
        done_pulse = CH_NONE;
        if (state_reg == ST_DONE)
            done_pulse[ch_reg] = 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            irq_reg <= CH_NONE;
            busy_reg <= CH_NONE;
        end else begin
            irq_reg <= done_pulse & last;
            busy_reg <= (busy_reg | i_start) & ~(done_pulse & last);
        end
    end

    assign o_bus = bus_reg;
    assign o_block_irq = irq_reg;
    assign o_busy = busy_reg;
endmodule : peripheral_sram_dma_core
`default_nettype wire

// File: tb/dma_far_side.sv
// Far side model: stalling memory arbiter with an address-derived data pattern
`timescale 1ns/1ps
`default_nettype none
module dma_far_side
    import dma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire bus_req_t i_bus,
    output logic o_grant,
    output logic [DATA_W-1:0] o_rdata
);
    logic [7:0] stall_reg;
    wire logic [DATA_W-1:0] word = i_bus.addr ^ 16'hA5C3;
    assign o_grant = i_bus.req && (stall_reg[1:0] != 2'h0);
    // Data is only valid in a read grant cycle
    assign o_rdata = (o_grant && !i_bus.we) ? word : ~word;
    always_ff @(posedge i_clk) begin
        stall_reg <= !i_rstn ? 8'h5A : {stall_reg[6:0], ^(stall_reg & 8'hB8)};
    end
endmodule : dma_far_side
`default_nettype wire

// File: tb/dma_core_assertions.sv
// Port checks on the transfer engine
`timescale 1ns/1ps
`default_nettype none
module dma_core_checker
    import dma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire ch_cfg_t [NUM_CH-1:0] i_cfg,
    input wire logic [NUM_CH-1:0] i_start,
    input wire logic i_grant,
    input wire bus_req_t o_bus,
    input wire logic [NUM_CH-1:0] o_block_irq,
    input wire logic [NUM_CH-1:0] o_busy
);
    logic [NUM_CH-1:0] en_start;
    always_comb for (int c = 0; c < NUM_CH; c++) en_start[c] = i_start[c] & i_cfg[c].enable;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ========================================================================
    // Properties
    sequence s_rd_grant; o_bus.req && i_grant && !o_bus.we; endsequence
    sequence s_wr_issue; !o_bus.req ##1 (o_bus.req && o_bus.we); endsequence
    property p_hold;
        o_bus.req && !i_grant |=> o_bus.req && $stable(o_bus.addr) && $stable(o_bus.we)
            && $stable(o_bus.wdata);
    endproperty
    property p_drop; o_bus.req && i_grant |=> !o_bus.req; endproperty
    property p_rd_wr; s_rd_grant |=> s_wr_issue; endproperty
    property p_irq_pulse; o_block_irq != CH_NONE |=> o_block_irq == CH_NONE; endproperty
    property p_irq_wr;
        o_block_irq != CH_NONE |-> $past(o_bus.req && i_grant && o_bus.we, 2);
    endproperty
    property p_irq_busy; (o_block_irq & ~$past(o_busy, 4)) == CH_NONE; endproperty
    property p_start;
        en_start != CH_NONE |=> (o_busy & $past(en_start)) == $past(en_start);
    endproperty
    property p_idle; o_busy == CH_NONE |-> !o_bus.req; endproperty
    a_hold: assert property (p_hold) else $error("request not held");
    a_drop: assert property (p_drop) else $error("request kept after grant");
    a_rd_wr: assert property (p_rd_wr) else $error("write did not follow read");
    a_irq_pulse: assert property (p_irq_pulse) else $error("block pulse too long");
    a_irq_wr: assert property (p_irq_wr) else $error("block pulse without write");
    a_irq_busy: assert property (p_irq_busy) else $error("pulse on idle channel");
    a_start: assert property (p_start) else $error("start did not arm");
    a_idle: assert property (p_idle) else $error("request while idle");
endmodule : dma_core_checker
bind peripheral_sram_dma_core dma_core_checker chk_u (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_cfg(i_cfg), .i_start(i_start), .i_grant(i_grant), .o_bus(o_bus),
    .o_block_irq(o_block_irq), .o_busy(o_busy));
`default_nettype wire

// File: tb/peripheral_sram_dma_core_tb.sv
// Self-checking bench for the transfer engine
`timescale 1ns/1ps
`default_nettype none
module peripheral_sram_dma_core_tb;
    import dma_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    ch_cfg_t [NUM_CH-1:0] i_cfg = '0;
    logic [NUM_CH-1:0] i_start = '0;
    logic [SEL_W-1:0] i_periph_req = '0;
    logic i_grant;
    logic [DATA_W-1:0] i_rdata;
    bus_req_t o_bus;
    logic [NUM_CH-1:0] o_block_irq;
    logic [NUM_CH-1:0] o_busy;
    int n_fail = 0;
    int samples_checked = 0;
    int n_wr = 0;
    int n_irq = 0;
    logic [31:0] rng = 32'h530454CB;
    logic [31:0] exp_q[$];
    peripheral_sram_dma_core dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg(i_cfg),
        .i_start(i_start), .i_periph_req(i_periph_req), .i_grant(i_grant),
        .i_rdata(i_rdata), .o_bus(o_bus), .o_block_irq(o_block_irq), .o_busy(o_busy));
    dma_far_side far_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(o_bus), .o_grant(i_grant),
        .o_rdata(i_rdata));
    initial forever #25 i_clk = ~i_clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic [31:0] exp_word(input int c, input int w);
        logic [ADDR_W-1:0] s;
        s = i_cfg[c].sram_start + (i_cfg[c].post_inc ? 16'(2 * w) : 16'h0000);
        return i_cfg[c].dir ? {i_cfg[c].periph_addr, s ^ 16'hA5C3}
            : {s, i_cfg[c].periph_addr ^ 16'hA5C3};
    endfunction : exp_word
    task automatic give_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic wait_for(input int n);
        int k;
        k = 0;
        while (k < 3000 && (n == 0 ? o_busy !== CH_NONE : n_wr < n)) begin
            @(posedge i_clk);
            k++;
        end
        if (k == 3000) begin
            $display("CHECK FAILED wait expected done seen timeout");
            n_fail++;
            give_verdict;
        end
    endtask : wait_for
    // ========================================================================
    // Result watcher
    always @(posedge i_clk) begin
        n_irq += $countones(o_block_irq);
        if (o_bus.req === 1'b1 && i_grant === 1'b1 && o_bus.we === 1'b1) begin
            n_wr++;
            samples_checked++;
            if (exp_q.size() == 0 || exp_q[0] !== {o_bus.addr, o_bus.wdata}) begin
                $display("CHECK FAILED write expected %h seen %h", exp_q[0],
                    {o_bus.addr, o_bus.wdata});
                n_fail++;
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    // ========================================================================
    // Stimulus
    initial begin
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            @(posedge i_clk);
            for (int c = 0; c < NUM_CH; c++) begin
                rng = xs(rng);
                i_cfg[c] <= '{1'b1, c[0], c != 3, 4'(4 * r + c), rng[15:0],
                    {rng[31:17], 1'b0}, 14'h0001};
            end
            @(posedge i_clk);
            i_start <= 4'hF;
            @(posedge i_clk);
            i_start <= 4'h0;
            for (int w = 0; w < 2; w++) begin
                for (int c = 0; c < NUM_CH; c++) exp_q.push_back(exp_word(c, w));
                i_periph_req <= 8'h0F << (4 * r);
                @(posedge i_clk);
                i_periph_req <= 8'h00;
                wait_for(4 * (2 * r + w + 1));
            end
            wait_for(0);
            repeat (4) @(posedge i_clk);
            samples_checked++;
            if (n_irq !== 4 * (r + 1)) begin
                $display("CHECK FAILED block pulses expected %0d seen %0d", 4 * (r + 1), n_irq);
                n_fail++;
            end
        end
        give_verdict;
    end
endmodule : peripheral_sram_dma_core_tb
`default_nettype wire
